/* design/pbpc_top.sv */
// low-nibble pin control: apb registers, input synchroniser and registered pin drive
`timescale 1ns/1ps
`include "pbpc_cfg.svh"
module pbpc_top
  import pbpc_pkg::*;
#(
  parameter pbpc_nib_type DBG_PIN_MASK = `PBPC_DBG_PIN_MASK
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_circuit_debug_mode,
  input wire logic [2:0] pmp_sel,
  input wire logic pmp_byte_enable_out,
  input wire logic pmp_addr_3_out,
  input wire logic pmp_addr_2_out,
  input wire pbpc_nib_type periph_out_sel,
  input wire pbpc_nib_type periph_out_val,
  input wire pbpc_nib_type pin_in,
  output pbpc_nib_type pin_out,
  output pbpc_nib_type pin_oe,
  output pbpc_nib_type pin_pullup_en,
  output pbpc_nib_type pin_analog_en,
  output pbpc_nib_type periph_din
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic pbpc_reg_type pbpc_decode(input logic [7:0] addr);
    unique case (addr)
      `PBPC_OFF_DIR: pbpc_decode = PBPC_REG_DIR;
      `PBPC_OFF_LAT: pbpc_decode = PBPC_REG_LAT;
      `PBPC_OFF_PORT: pbpc_decode = PBPC_REG_PORT;
      `PBPC_OFF_ANA: pbpc_decode = PBPC_REG_ANA;
      `PBPC_OFF_CTRL: pbpc_decode = PBPC_REG_CTRL;
      default: pbpc_decode = PBPC_REG_NONE;
    endcase
  endfunction : pbpc_decode

  pbpc_nib_type port_direction_bits_q, port_direction_bits_d;
  pbpc_nib_type port_output_latch_q, port_output_latch_d;
  pbpc_nib_type analog_config_reg_b_q, analog_config_reg_b_d;
  logic pullup_disable_n_q, pullup_disable_n_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  pbpc_nib_type sync1_q, sync2_q;
  pbpc_nib_type oe_q, out_q, pu_q, ana_q, din_q;
  pbpc_nib_type oe_d, out_d, pu_d, ana_d, din_d;
  pbpc_nib_type dbg_pins;
  pbpc_reg_type sel_reg;
  logic wr_go;
  pbpc_nib_type ana_out_mask;

  assign dbg_pins = in_circuit_debug_mode ? DBG_PIN_MASK : 4'h0;

  // ----------------------------------------
  // apb register group
  // ----------------------------------------
  always_comb begin
    sel_reg = pbpc_decode(paddr);
    // zero wait: pready rises in the access phase of every transfer
    wr_go = psel & penable & pready_q & pwrite & pstrb[0];
    port_direction_bits_d = port_direction_bits_q;
    port_output_latch_d = port_output_latch_q;
    analog_config_reg_b_d = analog_config_reg_b_q;
    pullup_disable_n_d = pullup_disable_n_q;
    pready_d = psel & ~penable;
    pslverr_d = psel & ~penable & (sel_reg == PBPC_REG_NONE);
    prdata_d = 32'h0000_0000;
    if (wr_go) begin
      unique case (sel_reg)
        PBPC_REG_DIR: port_direction_bits_d = pwdata[3:0];
        // a port write lands in the output latch
        PBPC_REG_LAT, PBPC_REG_PORT: port_output_latch_d = pwdata[3:0];
        PBPC_REG_ANA: analog_config_reg_b_d = pwdata[3:0];
        PBPC_REG_CTRL: pullup_disable_n_d = pwdata[`PBPC_CTRL_PUDN_BIT];
        PBPC_REG_NONE: pullup_disable_n_d = pullup_disable_n_q;
      endcase
    end
    if (psel & ~penable & ~pwrite) begin
      unique case (sel_reg)
        PBPC_REG_DIR: prdata_d[3:0] = port_direction_bits_q;
        PBPC_REG_LAT: prdata_d[3:0] = port_output_latch_q;
        PBPC_REG_PORT: prdata_d[3:0] = din_q;
        PBPC_REG_ANA: prdata_d[3:0] = analog_config_reg_b_q;
        PBPC_REG_CTRL: begin
          prdata_d[`PBPC_CTRL_PUDN_BIT] = pullup_disable_n_q;
          prdata_d[`PBPC_CTRL_DBG_BIT] = in_circuit_debug_mode;
        end
        PBPC_REG_NONE: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_direction_bits_q <= `PBPC_RST_DIR;
      port_output_latch_q <= `PBPC_RST_LAT;
      analog_config_reg_b_q <= `PBPC_RST_ANA;
      pullup_disable_n_q <= `PBPC_RST_PUDN;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      port_direction_bits_q <= port_direction_bits_d;
      port_output_latch_q <= port_output_latch_d;
      analog_config_reg_b_q <= analog_config_reg_b_d;
      pullup_disable_n_q <= pullup_disable_n_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------
  // pin steering
  // ----------------------------------------
  pbpc_pin_mux u_mux (
    .dir(port_direction_bits_q),
    .lat(port_output_latch_q),
    .ana_dig(analog_config_reg_b_q),
    .pud_n(pullup_disable_n_q),
    .dbg(dbg_pins),
    .pmp_en({pmp_sel, 1'b0}),
    .pmp_val({pmp_addr_2_out, pmp_addr_3_out, pmp_byte_enable_out, 1'b0}),
    .per_sel(periph_out_sel),
    .per_val(periph_out_val),
    .pin_sync(sync2_q),
    .oe_d(oe_d),
    .out_d(out_d),
    .pu_d(pu_d),
    .ana_d(ana_d),
    .din_d(din_d)
  );

  // ----------------------------------------
  // pin registers
  // ----------------------------------------
  // pad levels are asynchronous, so two flops before anything reads them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      oe_q <= 4'h0;
      out_q <= 4'h0;
      pu_q <= 4'h0;
      ana_q <= `PBPC_RST_ANA_EN;
      din_q <= 4'h0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      oe_q <= oe_d;
      out_q <= out_d;
      pu_q <= pu_d;
      ana_q <= ana_d;
      din_q <= din_d;
    end
  end

  assign pin_oe = oe_q;
  assign pin_out = out_q;
  assign pin_pullup_en = pu_q;
  assign pin_analog_en = ana_q;
  assign periph_din = din_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // analog pins that should plainly drive their latch
  assign ana_out_mask = ~port_direction_bits_q & ~analog_config_reg_b_q & ~{pmp_sel, 1'b0} & ~periph_out_sel & ~dbg_pins;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_input_hiz: assert property (
    (port_direction_bits_q == 4'hF && pmp_sel == 3'h0) |=> pin_oe == 4'h0)
    else $error("input pins still driven");

  chk_latch_drive: assert property (
    (port_direction_bits_q == 4'h0 && pmp_sel == 3'h0 && periph_out_sel == 4'h0 && !in_circuit_debug_mode)
    |=> (pin_oe == 4'hF && pin_out == $past(port_output_latch_q)))
    else $error("outputs do not follow latch");

  chk_pullup_gate: assert property (
    pullup_disable_n_q |=> pin_pullup_en == 4'h0)
    else $error("pull-up on while disabled");

  chk_analog_gate: assert property (
    1'b1 |=> ((pin_pullup_en | periph_din) & ~$past(analog_config_reg_b_q)) == 4'h0)
    else $error("analog pin keeps digital path");

  chk_analog_drive: assert property (
    ana_out_mask != 4'h0
    |=> ((pin_oe & $past(ana_out_mask)) == $past(ana_out_mask)
         && ((pin_out ^ $past(port_output_latch_q)) & $past(ana_out_mask)) == 4'h0))
    else $error("analog select changed output");

  chk_reset_analog: assert property (
    $rose(presetn) |-> (analog_config_reg_b_q == 4'h0 && pin_analog_en == 4'hF))
    else $error("pins not analog after reset");

  chk_debug_pins: assert property (
    in_circuit_debug_mode |=> ((pin_oe | pin_pullup_en | periph_din) & DBG_PIN_MASK) == 4'h0)
    else $error("debug pins still active");

  chk_pmp_override: assert property (
    (pmp_sel[0] && !(in_circuit_debug_mode && DBG_PIN_MASK[1]))
    |=> (pin_oe[1] && pin_out[1] == $past(pmp_byte_enable_out)))
    else $error("pmp byte enable not driven");

  chk_analog_read: assert property (
    (psel && !penable && !pwrite && paddr == `PBPC_OFF_PORT)
    |=> (prdata[3:0] & ~$past(analog_config_reg_b_q, 2)) == 4'h0)
    else $error("analog pin read nonzero");

  chk_output_pullup: assert property (
    1'b1 |=> (pin_pullup_en & ~$past(port_direction_bits_q)) == 4'h0)
    else $error("pull-up on an output");

endmodule : pbpc_top

/* include/pbpc_cfg.svh */
// register map, reset values and field positions of the low-nibble pin control block
`ifndef PBPC_CFG_SVH
`define PBPC_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PBPC_OFF_DIR 8'h00
`define PBPC_OFF_LAT 8'h04
`define PBPC_OFF_PORT 8'h08
`define PBPC_OFF_ANA 8'h0C
`define PBPC_OFF_CTRL 8'h10

// ----------------------------------------
// reset values
// ----------------------------------------
`define PBPC_RST_DIR 4'hF
`define PBPC_RST_LAT 4'h0
`define PBPC_RST_ANA 4'h0
`define PBPC_RST_PUDN 1'b1
`define PBPC_RST_ANA_EN 4'hF

// ----------------------------------------
// field positions and defaults
// ----------------------------------------
`define PBPC_CTRL_PUDN_BIT 0
`define PBPC_CTRL_DBG_BIT 1
`define PBPC_DBG_PIN_MASK 4'hC

`endif

/* include/pbpc_pkg.sv */
// types shared by the low-nibble pin control block
package pbpc_pkg;
  typedef logic [3:0] pbpc_nib_type;
  typedef enum {
    PBPC_REG_DIR,
    PBPC_REG_LAT,
    PBPC_REG_PORT,
    PBPC_REG_ANA,
    PBPC_REG_CTRL,
    PBPC_REG_NONE
  } pbpc_reg_type;
endpackage : pbpc_pkg

/* design/pbpc_pin_mux.sv */
// per-pin direction, override, pull-up and analog gating for four pins
`timescale 1ns/1ps
module pbpc_pin_mux
  import pbpc_pkg::*;
(
  input wire pbpc_nib_type dir,
  input wire pbpc_nib_type lat,
  input wire pbpc_nib_type ana_dig,
  input wire logic pud_n,
  input wire pbpc_nib_type dbg,
  input wire pbpc_nib_type pmp_en,
  input wire pbpc_nib_type pmp_val,
  input wire pbpc_nib_type per_sel,
  input wire pbpc_nib_type per_val,
  input wire pbpc_nib_type pin_sync,
  output pbpc_nib_type oe_d,
  output pbpc_nib_type out_d,
  output pbpc_nib_type pu_d,
  output pbpc_nib_type ana_d,
  output pbpc_nib_type din_d
);
  pbpc_nib_type drv_pmp;
  pbpc_nib_type drv_lat;
  pbpc_nib_type dig_on;

  // ----------------------------------------
  // pin steering
  // ----------------------------------------
  always_comb begin
    drv_pmp = pmp_en & ~dbg;
    drv_lat = ~dir & ~dbg & ~drv_pmp;
    dig_on = ana_dig & ~dbg;
    oe_d = drv_pmp | drv_lat;
    // peripheral outputs only reach the pin when software set dir to output
    out_d = ((drv_pmp & pmp_val) | (drv_lat & per_sel & per_val) | (drv_lat & ~per_sel & lat));
    ana_d = ~ana_dig & ~dbg;
    pu_d = {4{~pud_n}} & dir & dig_on & ~drv_pmp;
    din_d = pin_sync & dig_on;
  end
endmodule : pbpc_pin_mux

/* test/pbpc_board_model.sv */
// board side of the four pins: external drivers, weak pull-ups and floating pads
`timescale 1ns/1ps
module pbpc_board_model
  import pbpc_pkg::*;
(
  input wire logic pclk,
  input wire pbpc_nib_type pin_out,
  input wire pbpc_nib_type pin_oe,
  input wire pbpc_nib_type pin_pullup_en,
  input wire pbpc_nib_type ext_val,
  input wire pbpc_nib_type ext_en,
  output pbpc_nib_type pin_in
);
  // ----------------------------------------
  // pad level
  // ----------------------------------------
  // a floating pad toggles, so a stale level never passes for a real one
  pbpc_nib_type float_q = 4'h5;
  always @(posedge pclk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_q[i];
    end
  end
endmodule : pbpc_board_model

/* test/tb.sv */
// self-checking bench for the low-nibble pin control block
`timescale 1ns/1ps
`include "pbpc_cfg.svh"
module tb
  import pbpc_pkg::*;
();
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic dbg = 1'b0;
  logic [2:0] pmp_sel = 3'h0;
  logic pmp_be = 1'b0;
  logic pmp_a3 = 1'b0;
  logic pmp_a2 = 1'b0;
  pbpc_nib_type periph_out_sel = 4'h0;
  pbpc_nib_type periph_out_val = 4'h0;
  pbpc_nib_type ext_val = 4'hF;
  pbpc_nib_type ext_en = 4'hF;
  pbpc_nib_type pin_in, pin_out, pin_oe, pin_pullup_en, pin_analog_en, periph_din;
  logic [31:0] rdv;
  logic erv;
  int fail_count = 0;
  int compares = 0;

  always #4 pclk = ~pclk;

  pbpc_top pbpc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_circuit_debug_mode(dbg), .pmp_sel(pmp_sel), .pmp_byte_enable_out(pmp_be), .pmp_addr_3_out(pmp_a3),
    .pmp_addr_2_out(pmp_a2), .periph_out_sel(periph_out_sel), .periph_out_val(periph_out_val),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_analog_en(pin_analog_en), .periph_din(periph_din));
  pbpc_board_model pbpc_board_model_i (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic check_n(input string what, input pbpc_nib_type seen, input pbpc_nib_type exp);
    check(what, {28'h0000000, seen}, {28'h0000000, exp});
  endtask : check_n
  // one idle cycle before each setup keeps psel from being assigned twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no local limit: only the watchdog ends a hung wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h00000000);
    check(what, rdv, exp);
  endtask : rd
  // pins follow one edge after a write, reads lag pads by three
  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask : settle
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #32000;
    fail_count++;
    end_of_test();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    check_n("analog_en", pin_analog_en, `PBPC_RST_ANA_EN);
    check_n("oe", pin_oe, 4'h0);
    check_n("pullup", pin_pullup_en, 4'h0);
    check_n("out", pin_out, 4'h0);
    check("pready", {31'h00000000, pready}, 32'h00000000);
    rd(`PBPC_OFF_DIR, 32'h0000000F, "dir");
    rd(`PBPC_OFF_ANA, 32'h00000000, "ana");
    rd(`PBPC_OFF_CTRL, 32'h00000001, "ctrl");
    rd(`PBPC_OFF_PORT, 32'h00000000, "port");
    rd(8'h14, 32'h00000000, "unmapped");
    check("slverr", {31'h00000000, erv}, 32'h00000001);
    $display("test reset done");
    ext_val <= 4'hA;
    wr(`PBPC_OFF_ANA, 32'h0000000C);
    wr(`PBPC_OFF_CTRL, 32'h00000000);
    settle();
    rd(`PBPC_OFF_PORT, 32'h00000008, "port in");
    check_n("din", periph_din, 4'h8);
    check_n("analog_en", pin_analog_en, 4'h3);
    check_n("pullup", pin_pullup_en, 4'hC);
    $display("test input done");
    wr(`PBPC_OFF_PORT, 32'h00000005);
    rd(`PBPC_OFF_LAT, 32'h00000005, "lat");
    pstrb <= 4'h0;
    wr(`PBPC_OFF_LAT, 32'h0000000F);
    pstrb <= 4'hF;
    rd(`PBPC_OFF_LAT, 32'h00000005, "lat no strobe");
    wr(`PBPC_OFF_DIR, 32'h0000000C);
    settle();
    check_n("oe", pin_oe, 4'h3);
    check_n("out", pin_out, 4'h1);
    check_n("pullup", pin_pullup_en, 4'hC);
    $display("test output done");
    wr(`PBPC_OFF_DIR, 32'h0000000F);
    pmp_sel <= 3'h7;
    pmp_be <= 1'b1;
    pmp_a2 <= 1'b1;
    settle();
    check_n("oe", pin_oe, 4'hE);
    check_n("out", pin_out, 4'hA);
    check_n("pullup", pin_pullup_en, 4'h0);
    $display("test pmp done");
    dbg <= 1'b1;
    settle();
    check_n("oe", pin_oe, 4'h2);
    check_n("out", pin_out, 4'h2);
    check_n("din", periph_din, 4'h0);
    rd(`PBPC_OFF_CTRL, 32'h00000002, "ctrl dbg");
    dbg <= 1'b0;
    pmp_sel <= 3'h0;
    $display("test debug done");
    wr(`PBPC_OFF_LAT, 32'h00000000);
    wr(`PBPC_OFF_DIR, 32'h00000000);
    periph_out_sel <= 4'h5;
    periph_out_val <= 4'hF;
    settle();
    check_n("oe", pin_oe, 4'hF);
    check_n("out", pin_out, 4'h5);
    $display("test periph done");
    end_of_test();
  end
endmodule : tb
